// ===== hw/tec_pkg.sv
package tec_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SYSCFG = 4'h8;
  // Control register field positions
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;
  // System config register fields (clock select, divider output, direction)
  localparam int CLKSEL_HI = 1;
  localparam int CLKSEL_LO = 0;
  localparam int PFD_SEL_BIT = 2;
  localparam int PIN_DIR_BIT = 3;
  // Reset values, control write mask and sys/4 divider terminal count
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] SYSCFG_RST = 8'h08;
  localparam logic [7:0] CTRL_WMASK = 8'hdf;
  localparam logic [1:0] FSYS4_DIV = 2'h3;

  typedef enum logic [1:0] {
    TEC_MODE_NONE = 2'h0,
    TEC_MODE_EVENT = 2'h1,
    TEC_MODE_TIMER = 2'h2,
    TEC_MODE_PULSE = 2'h3
  } tec_mode_t;

  typedef enum logic [1:0] {
    TEC_CLK_SYS = 2'h0,
    TEC_CLK_SYS4 = 2'h1,
    TEC_CLK_LOW_SPEED_INTERNAL_OSC = 2'h2,
    TEC_CLK_LIRC2 = 2'h3
  } tec_clksel_t;

  typedef enum {TEC_PW_IDLE, TEC_PW_WAIT, TEC_PW_COUNT} tec_pw_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tec_wb_req_t;

  // All module state
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] preload;
    logic [7:0] ctrl;
    logic [7:0] syscfg;
    logic [6:0] psc;
    logic [1:0] div4;
    logic pin_q;
    logic low_speed_internal_osc_q;
    logic src_q;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    tec_pw_t pw;
  } tec_state_t;
endpackage

// ===== hw/tec_timer.sv
`timescale 1ns/1ps
// Contract
// - One 8-bit counter, counts up by one per qualifying pulse or edge.
// - Control bits 7:6 select timer, event counting or pulse capture.
// - On overflow raise interrupt, reload from preload, keep counting.
// - Preload write while disabled is copied into counter at once.
// - Preload write while running waits in preload until next overflow.
// - Reading the count register returns present counter contents.
// - Control bit 4 high runs the counter, low stops it.
// - Control bits 2:0 divide internal clock; ignored for external pin.
// - Internal clock is system clock, system clock/4, or low-speed osc.
// - Event mode counts pin transitions of polarity picked by edge select.
// - Control bit 3 selects active edge in event and pulse modes.
// - Pin drives divider output only if selected and direction is output.
// - Preload content after power-on is unknown, no reset value needed.
// - Mode 00 none, 01 event, 10 timer, 11 pulse capture.
// - Event mode edge select 0 counts rising, 1 counts falling.
// - Pulse mode waits active edge, counts, stops and clears run bit.
module tec_timer (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire tec_pkg::tec_wb_req_t wb_req, // Wishbone request
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic low_speed_internal_osc_clk_i, // Low-speed osc level, sampled
  input wire logic timer_pin_i, // Shared timer pin input level
  input wire logic pfd_i, // Frequency-divider signal
  output logic timer_pin_o, // Pin output value
  output logic timer_pin_oe, // Pin output enable
  output logic pin_read_o, // Normal input reading of the pin
  output logic irq_o // Overflow interrupt pulse
);
  tec_pkg::tec_state_t st_r;
  tec_pkg::tec_state_t st_nxt;

  // Divide-by-2^n tap from the free-running prescaler
  function automatic logic psc_tap(input logic [2:0] code, input logic [6:0] p);
    psc_tap = (code == 3'h0) ? 1'b1 : (p[code - 3'h1 +: 1] == 1'b0) &&
              ((p & ((7'h1 << code) - 7'h1)) == 7'h0) ? 1'b1 : 1'b0;
  endfunction

  logic bus_req;
  logic wr_count;
  logic wr_ctrl;
  logic wr_cfg;
  logic run;
  logic src_tick;
  logic int_tick;
  logic pin_rise;
  logic pin_fall;
  logic active_edge;
  logic end_edge;
  logic do_inc;
  logic [7:0] rd_byte;
  tec_pkg::tec_mode_t mode;
  tec_pkg::tec_clksel_t csel;

  // Bus decode; ack answers one cycle after the strobe and drops after
  assign bus_req = wb_req.cyc && wb_req.stb && !st_r.ack;
  assign wr_count = bus_req && wb_req.we && wb_req.sel[0] && wb_req.adr == tec_pkg::ADDR_COUNT;
  assign wr_ctrl = bus_req && wb_req.we && wb_req.sel[0] && wb_req.adr == tec_pkg::ADDR_CTRL;
  assign wr_cfg = bus_req && wb_req.we && wb_req.sel[0] && wb_req.adr == tec_pkg::ADDR_SYSCFG;

  assign mode = tec_pkg::tec_mode_t'(st_r.ctrl[tec_pkg::MODE_HI:tec_pkg::MODE_LO]);
  assign run = st_r.ctrl[tec_pkg::RUN_BIT];
  assign csel = tec_pkg::tec_clksel_t'(st_r.syscfg[tec_pkg::CLKSEL_HI:tec_pkg::CLKSEL_LO]);

  // Source clock ticks: mclk, mclk/4, or low-speed osc falling edge
  always_comb begin
    unique case (csel)
      tec_pkg::TEC_CLK_SYS: src_tick = 1'b1;
      tec_pkg::TEC_CLK_SYS4: src_tick = (st_r.div4 == tec_pkg::FSYS4_DIV);
      tec_pkg::TEC_CLK_LOW_SPEED_INTERNAL_OSC, tec_pkg::TEC_CLK_LIRC2: src_tick = st_r.low_speed_internal_osc_q && !low_speed_internal_osc_clk_i;
    endcase
  end

  // Prescaled internal tick; prescaler counts source ticks only
  assign int_tick = src_tick && psc_tap(st_r.ctrl[tec_pkg::PSC_HI:tec_pkg::PSC_LO], st_r.psc);

  // Pin edges, pin taken as synchronous
  assign pin_rise = !st_r.pin_q && timer_pin_i;
  assign pin_fall = st_r.pin_q && !timer_pin_i;
  assign active_edge = st_r.ctrl[tec_pkg::EDGE_BIT] ? pin_fall : pin_rise;
  // Pulse mode: edge select 0 starts on falling, ends on rising
  assign end_edge = st_r.ctrl[tec_pkg::EDGE_BIT] ? pin_fall : pin_rise;

  // Increment qualifier per mode
  always_comb begin
    unique case (mode)
      tec_pkg::TEC_MODE_EVENT: do_inc = run && active_edge;
      tec_pkg::TEC_MODE_TIMER: do_inc = run && int_tick;
      tec_pkg::TEC_MODE_PULSE: do_inc = run && st_r.pw == tec_pkg::TEC_PW_COUNT && int_tick && !end_edge;
      tec_pkg::TEC_MODE_NONE: do_inc = 1'b0;
    endcase
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (wb_req.adr == tec_pkg::ADDR_COUNT) begin
      rd_byte = st_r.count;
    end else if (wb_req.adr == tec_pkg::ADDR_CTRL) begin
      rd_byte = st_r.ctrl;
    end else if (wb_req.adr == tec_pkg::ADDR_SYSCFG) begin
      rd_byte = st_r.syscfg;
    end
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = bus_req;
    st_nxt.irq = 1'b0;
    st_nxt.pin_q = timer_pin_i;
    st_nxt.low_speed_internal_osc_q = low_speed_internal_osc_clk_i;
    st_nxt.div4 = st_r.div4 + 2'h1;
    if (src_tick) begin
      st_nxt.psc = st_r.psc + 7'h1;
    end
    if (bus_req && !wb_req.we) begin
      st_nxt.rdat = {24'h000000, rd_byte};
    end
    // Counting; overflow past full count reloads preload
    if (do_inc) begin
      if (st_r.count == 8'hff) begin
        st_nxt.count = st_r.preload;
        st_nxt.irq = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
    // Pulse capture sequencing
    if (mode == tec_pkg::TEC_MODE_PULSE && run) begin
      unique case (st_r.pw)
        tec_pkg::TEC_PW_IDLE, tec_pkg::TEC_PW_WAIT: begin
          st_nxt.pw = (st_r.ctrl[tec_pkg::EDGE_BIT] ? pin_rise : pin_fall)
                      ? tec_pkg::TEC_PW_COUNT : tec_pkg::TEC_PW_WAIT;
        end
        tec_pkg::TEC_PW_COUNT: begin
          if (end_edge) begin
            st_nxt.pw = tec_pkg::TEC_PW_IDLE;
            st_nxt.ctrl[tec_pkg::RUN_BIT] = 1'b0;
          end
        end
      endcase
    end else begin
      st_nxt.pw = tec_pkg::TEC_PW_IDLE;
    end
    // Software writes; a control write lands after the hardware clear
    if (wr_count) begin
      st_nxt.preload = wb_req.dat[7:0];
      if (!run) begin
        st_nxt.count = wb_req.dat[7:0];
      end
    end
    if (wr_ctrl) begin
      st_nxt.ctrl = wb_req.dat[7:0] & tec_pkg::CTRL_WMASK;
      st_nxt.pw = tec_pkg::TEC_PW_IDLE;
    end
    if (wr_cfg) begin
      st_nxt.syscfg = {4'h0, wb_req.dat[3:0]};
    end
  end

  // State register; preload has no meaningful reset, zeroed for tidiness
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.ctrl <= tec_pkg::CTRL_RST;
      st_r.syscfg <= tec_pkg::SYSCFG_RST;
      st_r.pw <= tec_pkg::TEC_PW_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign irq_o = st_r.irq && clk_en;
  assign pin_read_o = timer_pin_i;
  // Pin driven only with divider selected and direction output
  assign timer_pin_oe = st_r.syscfg[tec_pkg::PFD_SEL_BIT] && !st_r.syscfg[tec_pkg::PIN_DIR_BIT];
  assign timer_pin_o = timer_pin_oe ? pfd_i : 1'b0;

  // Assertions
  overflow_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && do_inc && st_r.count == 8'hff && !wr_count |=> st_r.irq && st_r.count == $past(st_r.preload))
    else $error("overflow did not reload and interrupt");
  irq_single_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.irq && clk_en && !(do_inc && st_r.count == 8'hff) |=> !st_r.irq)
    else $error("interrupt longer than one cycle");
  count_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && do_inc && st_r.count != 8'hff && !wr_count |=> st_r.count == $past(st_r.count) + 8'h01)
    else $error("counter did not step by one");
  stop_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !run && !wr_count |=> $stable(st_r.count)) else $error("stopped counter moved");
  preload_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr_count && !run |=> st_r.count == $past(wb_req.dat[7:0])) else $error("preload not copied");
  preload_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr_count && run && !do_inc |=> $stable(st_r.count)) else $error("running preload hit counter");
  pulse_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && mode == tec_pkg::TEC_MODE_PULSE && run && st_r.pw == tec_pkg::TEC_PW_COUNT && end_edge && !wr_ctrl
    |=> !run) else $error("pulse end did not clear run");
  mode_none_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_NONE |-> !do_inc) else $error("counting with no mode");
  pin_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    timer_pin_oe |-> st_r.syscfg[tec_pkg::PFD_SEL_BIT] && !st_r.syscfg[tec_pkg::PIN_DIR_BIT])
    else $error("pin driven without divider selection");
  ack_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && bus_req |=> wb_ack_o ##1 !wb_ack_o [*1]) else $error("ack shape wrong");

  // Preload captures every count write, running or not; otherwise it holds
  preload_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr_count |=> st_r.preload == $past(wb_req.dat[7:0]))
    else $error("preload write not captured");
  preload_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !wr_count |=> $stable(st_r.preload))
    else $error("preload changed without a write");

  // Control and config writes land with their masks applied
  ctrl_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr_ctrl |=> st_r.ctrl == ($past(wb_req.dat[7:0]) & tec_pkg::CTRL_WMASK))
    else $error("control write not applied");
  cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr_cfg |=> st_r.syscfg == {4'h0, $past(wb_req.dat[3:0])})
    else $error("config write not applied");
  // Only software changes mode, edge and ratio; hardware may only clear run
  ctrl_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !wr_ctrl |=> $stable(st_r.ctrl[7:5]) && $stable(st_r.ctrl[3:0]))
    else $error("control field changed without a write");
  run_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !wr_ctrl && !run |=> !run)
    else $error("run bit set by hardware");
  ctrl_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_r.ctrl[5]) else $error("unused control bit set");

  // Writes that miss the map or the low byte lane change nothing
  unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && bus_req && wb_req.we && !wr_count && !wr_ctrl && !wr_cfg
    |=> $stable(st_r.syscfg) && $stable(st_r.preload) && $stable(st_r.ctrl[7:5]))
    else $error("ignored write changed a register");
  ack_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !bus_req |=> !wb_ack_o) else $error("ack without request");
  read_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && bus_req && !wb_req.we && wb_req.adr == tec_pkg::ADDR_COUNT
    |=> wb_dat_o[7:0] == $past(st_r.count))
    else $error("count read wrong");
  read_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_dat_o[31:8] == 24'h000000) else $error("upper read lanes not zero");

  // Interrupt only ever follows a real overflow
  irq_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && !(do_inc && st_r.count == 8'hff) |=> !st_r.irq)
    else $error("interrupt without overflow");
  run_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !run |-> !do_inc) else $error("increment while stopped");

  // Event mode follows the pin edge alone, the prescaler plays no part
  event_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_EVENT && run && !st_r.ctrl[tec_pkg::EDGE_BIT] |-> do_inc == pin_rise)
    else $error("rising edge count wrong");
  event_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_EVENT && run && st_r.ctrl[tec_pkg::EDGE_BIT] |-> do_inc == pin_fall)
    else $error("falling edge count wrong");
  timer_tick_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_TIMER |-> do_inc == (run && int_tick))
    else $error("timer tick not counted");

  // Pulse mode waits for its start edge, then counts internal ticks
  pulse_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_PULSE && st_r.pw != tec_pkg::TEC_PW_COUNT |-> !do_inc)
    else $error("pulse counted before start edge");
  pulse_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && mode == tec_pkg::TEC_MODE_PULSE && run && st_r.pw != tec_pkg::TEC_PW_COUNT && !wr_ctrl &&
    (st_r.ctrl[tec_pkg::EDGE_BIT] ? pin_rise : pin_fall) |=> st_r.pw == tec_pkg::TEC_PW_COUNT)
    else $error("pulse start edge missed");
  pulse_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_PULSE && run && st_r.pw == tec_pkg::TEC_PW_COUNT && !end_edge |-> do_inc == int_tick)
    else $error("pulse tick not counted");
  pulse_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == tec_pkg::TEC_MODE_PULSE && st_r.pw == tec_pkg::TEC_PW_COUNT && end_edge |-> !do_inc)
    else $error("pulse end edge counted");
  pulse_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && mode != tec_pkg::TEC_MODE_PULSE |=> st_r.pw == tec_pkg::TEC_PW_IDLE)
    else $error("pulse sequencer left busy");
  pw_legal_a: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r.pw inside {tec_pkg::TEC_PW_IDLE, tec_pkg::TEC_PW_WAIT, tec_pkg::TEC_PW_COUNT})
    else $error("pulse sequencer state illegal");

  // Tick spacing while the timer runs; a freeze stretches it, so it is left out
  psc_none_a: assert property (@(posedge mclk) disable iff (!rst_n)
    csel == tec_pkg::TEC_CLK_SYS && st_r.ctrl[tec_pkg::PSC_HI:tec_pkg::PSC_LO] == 3'h0 |-> int_tick)
    else $error("undivided tick missing");
  psc_div2_a: assert property (@(posedge mclk) disable iff (!rst_n || !clk_en)
    mode == tec_pkg::TEC_MODE_TIMER && run && csel == tec_pkg::TEC_CLK_SYS && !wr_ctrl &&
    st_r.ctrl[tec_pkg::PSC_HI:tec_pkg::PSC_LO] == 3'h1 && int_tick |=> !int_tick ##1 int_tick)
    else $error("divide by two spacing wrong");
  psc_div4_a: assert property (@(posedge mclk) disable iff (!rst_n || !clk_en)
    mode == tec_pkg::TEC_MODE_TIMER && run && csel == tec_pkg::TEC_CLK_SYS && !wr_ctrl &&
    st_r.ctrl[tec_pkg::PSC_HI:tec_pkg::PSC_LO] == 3'h2 && int_tick |=> !int_tick [*3] ##1 int_tick)
    else $error("divide by four spacing wrong");
  psc_div8_a: assert property (@(posedge mclk) disable iff (!rst_n || !clk_en)
    mode == tec_pkg::TEC_MODE_TIMER && run && csel == tec_pkg::TEC_CLK_SYS && !wr_ctrl &&
    st_r.ctrl[tec_pkg::PSC_HI:tec_pkg::PSC_LO] == 3'h3 && int_tick |=> !int_tick [*7] ##1 int_tick)
    else $error("divide by eight spacing wrong");
  src_sys_a: assert property (@(posedge mclk) disable iff (!rst_n)
    csel == tec_pkg::TEC_CLK_SYS |-> src_tick) else $error("system clock tick missing");
  sys4_rate_a: assert property (@(posedge mclk) disable iff (!rst_n || !clk_en)
    mode == tec_pkg::TEC_MODE_TIMER && run && csel == tec_pkg::TEC_CLK_SYS4 && src_tick && !wr_cfg
    |=> !src_tick [*3] ##1 src_tick)
    else $error("quarter rate tick spacing wrong");
  slow_tick_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (csel == tec_pkg::TEC_CLK_LOW_SPEED_INTERNAL_OSC || csel == tec_pkg::TEC_CLK_LIRC2) && src_tick |-> !low_speed_internal_osc_clk_i)
    else $error("slow tick off its falling edge");

  // Pin follows the divider only while driven; clock enable low freezes all
  pin_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !timer_pin_oe |-> !timer_pin_o) else $error("pin value without drive");
  pin_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    timer_pin_oe |-> timer_pin_o == pfd_i) else $error("pin not following divider");
  pin_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_read_o == timer_pin_i) else $error("pin reading lost");
  freeze_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clk_en |=> $stable(st_r)) else $error("state moved while frozen");
  irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !clk_en |-> !irq_o) else $error("interrupt leaked while frozen");

  overflow_c: cover property (@(posedge mclk) disable iff (!rst_n) st_r.irq);
  event_c: cover property (@(posedge mclk) disable iff (!rst_n) mode == tec_pkg::TEC_MODE_EVENT && do_inc);
  pulse_c: cover property (@(posedge mclk) disable iff (!rst_n)
    st_r.pw == tec_pkg::TEC_PW_COUNT ##[1:200] !run);
  event_wrap_c: cover property (@(posedge mclk) disable iff (!rst_n) mode == tec_pkg::TEC_MODE_EVENT && st_r.irq);
  freeze_c: cover property (@(posedge mclk) disable iff (!rst_n) !clk_en && run);
endmodule // tec_timer

// ===== verification/tec_pulse_src.sv
`timescale 1ns/1ps
// Pulse source on the shared timer pin, level synchronous to mclk
module tec_pulse_src (
  input wire logic mclk, // System clock
  input wire logic start, // Begin a burst when idle
  input wire logic idle_lvl, // Pin level between bursts
  input wire logic [7:0] pulses, // Pulses per burst
  input wire logic [7:0] width, // Extra cycles per half pulse
  output logic pin, // Timer pin level
  output logic busy // Burst in progress
);
  logic [8:0] halves;
  logic [7:0] wait_cnt;
  initial begin
    pin = 1'b1;
    busy = 1'b0;
  end
  // Two transitions per pulse; pin always driven, rests at idle level
  always @(posedge mclk) begin
    if (!busy) begin
      pin <= idle_lvl;
      busy <= start;
      halves <= {pulses, 1'b0};
      wait_cnt <= width;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end else begin
      pin <= ~pin;
      wait_cnt <= width;
      halves <= halves - 9'h001;
      busy <= (halves != 9'h001);
    end
  end
endmodule // tec_pulse_src

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk, rst_n, ce, low_speed_internal_osc, freq_divider_output, go, idle, busy, pin, ack, pin_o, pin_oe, pin_rd, irq;
  logic [7:0] n, w, q, psc;
  logic [31:0] rdat;
  tec_pkg::tec_wb_req_t req;
  int failures, comparisons, cycles, irqs, base, t;

  tec_timer dut (.mclk(mclk), .rst_n(rst_n), .clk_en(ce), .wb_req(req), .wb_dat_o(rdat), .wb_ack_o(ack),
    .low_speed_internal_osc_clk_i(low_speed_internal_osc), .timer_pin_i(pin), .pfd_i(freq_divider_output), .timer_pin_o(pin_o), .timer_pin_oe(pin_oe),
    .pin_read_o(pin_rd), .irq_o(irq));
  tec_pulse_src src (.mclk(mclk), .start(go), .idle_lvl(idle), .pulses(n), .width(w), .pin(pin), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Slow oscillator falls every 16 cycles; irq tally; hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    low_speed_internal_osc <= cycles[3];
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  // Classic single cycle; waits for ack with no assumed latency
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h000000, d}};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat[7:0];
    req <= '0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("ERROR %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic burst(input logic [7:0] np, input logic [7:0] nw);
    @(posedge mclk);
    go <= 1'b1;
    n <= np;
    w <= nw;
    @(posedge mclk);
    go <= 1'b0;
    do @(posedge mclk); while (busy !== 1'b0);
  endtask
  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0; req = '0; freq_divider_output = 1'b0; go = 1'b0; idle = 1'b1; n = 8'h00; w = 8'h00; ce = 1'b1;
    failures = 0; comparisons = 0; cycles = 0; irqs = 0; low_speed_internal_osc = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // Control reset value, masked control bit, unmapped address
    wb(1'b0, tec_pkg::ADDR_CTRL, 8'h00); chk("ctrl_reset", tec_pkg::CTRL_RST, q);
    wb(1'b0, 4'hc, 8'h00); chk("unmapped", 8'h00, q);
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'hff);
    wb(1'b0, tec_pkg::ADDR_CTRL, 8'h00); chk("ctrl_rw", tec_pkg::CTRL_WMASK, q);
    $display("test registers done");
    // Event counting with both polarities across an overflow
    for (int e = 0; e < 2; e++) begin
      idle <= e[0];
      wb(1'b1, tec_pkg::ADDR_CTRL, {4'h4, e[0], 3'h0});
      wb(1'b1, tec_pkg::ADDR_COUNT, 8'hfe);
      wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk("count_load", 8'hfe, q);
      wb(1'b1, tec_pkg::ADDR_CTRL, {4'h5, e[0], 3'h0});
      wb(1'b1, tec_pkg::ADDR_COUNT, 8'h40);
      wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk("count_held", 8'hfe, q);
      base = irqs;
      burst(8'h03, 8'h03);
      wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk("count_events", 8'h41, q);
      chk("irq_pulses", 8'h01, 8'(irqs - base));
    end
    $display("test event done");
    // Timer mode: every prescale code, then sys/4 and slow oscillator
    for (int i = 0; i < 10; i++) begin
      psc = (i < 8) ? 8'(i) : 8'h00;
      t = (i < 8) ? (16 << i) : ((i == 8) ? 64 : 256);
      wb(1'b1, tec_pkg::ADDR_SYSCFG, (i < 8) ? 8'h08 : (8'(i - 7) | 8'h08));
      wb(1'b1, tec_pkg::ADDR_CTRL, 8'h80 | psc);
      wb(1'b1, tec_pkg::ADDR_COUNT, 8'h00);
      wb(1'b1, tec_pkg::ADDR_CTRL, 8'h90 | psc);
      repeat (t) @(posedge mclk);
      wb(1'b1, tec_pkg::ADDR_CTRL, 8'h80 | psc);
      wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk_rng("count_timer", 8'h0f, 8'h16, q);
    end
    $display("test timer done");
    // Clock enable low freezes a running counter
    wb(1'b1, tec_pkg::ADDR_SYSCFG, 8'h08);
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'h80);
    wb(1'b1, tec_pkg::ADDR_COUNT, 8'h00);
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'h90);
    ce <= 1'b0;
    repeat (50) @(posedge mclk);
    ce <= 1'b1;
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'h80);
    wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk_rng("count_frozen", 8'h01, 8'h05, q);
    $display("test freeze done");
    // Pulse capture: low pulse of 21 cycles, run bit self-clears
    wb(1'b1, tec_pkg::ADDR_SYSCFG, 8'h08);
    idle <= 1'b1;
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'hc0);
    wb(1'b1, tec_pkg::ADDR_COUNT, 8'h00);
    wb(1'b1, tec_pkg::ADDR_CTRL, 8'hd0);
    burst(8'h01, 8'h14);
    wb(1'b0, tec_pkg::ADDR_CTRL, 8'h00); chk("run_cleared", 8'hc0, q);
    wb(1'b0, tec_pkg::ADDR_COUNT, 8'h00); chk_rng("pulse_width", 8'h12, 8'h18, q);
    $display("test capture done");
    // Divider output only when selected and direction is output
    freq_divider_output <= 1'b1;
    wb(1'b1, tec_pkg::ADDR_SYSCFG, 8'h04); chk("pin_drive", 8'h03, {6'h00, pin_oe, pin_o});
    wb(1'b1, tec_pkg::ADDR_SYSCFG, 8'h0c); chk("pin_input", 8'h01, {6'h00, pin_oe, pin_rd});
    $display("test pin done");
    stop_test();
  end
endmodule // testbench
